// ==== rtl/sdb_pkg.sv ====
// Shared constants and types of the SDRAM bank and burst access model.
// Assumes the includer imports the whole package.
package sdb_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int ROW_W = 13;
  localparam int NUM_ROWS = 8192;
  localparam int DQ_W_X4 = 4;
  localparam int DQ_W_X8 = 8;
  localparam int DQ_W_X16 = 16;
  localparam int COLS_X4 = 2048;
  localparam int COLS_X8 = 1024;
  localparam int COLS_X16 = 512;
  localparam int COL_W_X4 = $clog2(COLS_X4);
  localparam int COL_W_X8 = $clog2(COLS_X8);
  localparam int COL_W_X16 = $clog2(COLS_X16);
  localparam int PRECHARGE_SELECT_BIT = 10;
  localparam int X4_COL_TOP_BIT = 11;

  // ==========================================================================
  // Mode word fields
  localparam int MR_BLEN_LSB = 0;
  localparam int MR_BLEN_W = 3;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_CL_W = 3;
  localparam int MR_WB_BIT = 9;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0020;
  localparam logic [MR_CL_W-1:0] CL_CODE_3 = 3'h3;
  localparam logic [MR_BLEN_W-1:0] BLEN_1 = 3'h0;
  localparam logic [MR_BLEN_W-1:0] BLEN_2 = 3'h1;
  localparam logic [MR_BLEN_W-1:0] BLEN_4 = 3'h2;
  localparam logic [MR_BLEN_W-1:0] BLEN_8 = 3'h3;
  localparam logic [MR_BLEN_W-1:0] BLEN_FULL = 3'h7;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TRP_NS = 20;
  localparam int TRFC_NS = 66;
  localparam int TRP_CYC = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRFC_CYC = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

  // ==========================================================================
  // Commands as {row strobe, column strobe, write enable}
  typedef enum logic [2:0] {
    CMD_LMR = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_BST = 3'b110,
    CMD_NOP = 3'b111
  } sdb_cmd_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_REFRESH = 2'b01,
    ST_PDOWN = 2'b10,
    ST_SELF = 2'b11
  } sdb_state_e;

  typedef enum logic [1:0] {
    BK_IDLE = 2'b00,
    BK_OPEN = 2'b01,
    BK_PRE = 2'b10
  } sdb_bank_e;

endpackage : sdb_pkg

// ==== rtl/sdb_bank.sv ====
// One bank: open row and precharge timing.
// Assumes the core decodes commands for this bank.
`timescale 1ns/10ps
`default_nettype none
module sdb_bank
  import sdb_pkg::*;
#(
  parameter int TRP_CYC_P = TRP_CYC
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Commands
  input wire logic act_in,
  input wire logic [ROW_W-1:0] row_in,
  input wire logic pre_in,
  // State
  output logic open_out,
  output logic idle_out,
  output logic [ROW_W-1:0] row_out
);

  // ==========================================================================
  // Bank state
  sdb_bank_e state_q, state_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [ROW_W-1:0] row_q, row_d;

  always_comb
  begin
    state_d = state_q;
    tmr_d = tmr_q;
    row_d = row_q;
    unique case (state_q)
      BK_IDLE:
      begin
        if (act_in)
        begin
          state_d = BK_OPEN;
          row_d = row_in;
        end
      end
      BK_OPEN:
      begin
        if (pre_in)
        begin
          state_d = BK_PRE;
          tmr_d = TMR_W'(TRP_CYC_P - 1);
        end
      end
      BK_PRE:
      begin
        if (tmr_q == '0)
          state_d = BK_IDLE;
        else
          tmr_d = tmr_q - TMR_W'(1);
      end
      default: state_d = BK_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q <= BK_IDLE;
      tmr_q <= '0;
      row_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      row_q <= row_d;
    end
  end

  assign open_out = state_q[0];
  assign idle_out = (state_q == BK_IDLE);
  assign row_out = row_q;

  // ==========================================================================
  // Checks
  AST_ACT_OPENS_ROW: assert property (@(posedge clk_in) disable iff (rst_in)
    (act_in && idle_out) |=> (open_out && row_out == $past(row_in)))
    else $error("activate did not open the given row");

  AST_PRECHARGE_TIME: assert property (@(posedge clk_in) disable iff (rst_in)
    (open_out && pre_in) |=> (!open_out && !idle_out) [*2] ##1 idle_out)
    else $error("bank precharge time wrong");

endmodule : sdb_bank
`default_nettype wire

// ==== rtl/sdb_burst.sv ====
// Burst column generator: sequential or interleaved order, fixed or full page.
// Assumes start and stop never arrive together.
`timescale 1ns/10ps
`default_nettype none
module sdb_burst
  import sdb_pkg::*;
#(
  parameter int COL_W = COL_W_X16
)(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic [COL_W-1:0] start_col_in,
  input wire logic [MR_BLEN_W-1:0] len_code_in,
  input wire logic interleave_in,
  input wire logic stop_in,
  // Column stream
  output logic valid_out,
  output logic busy_out,
  output logic last_out,
  output logic [COL_W-1:0] col_out
);

  // ==========================================================================
  // Burst counter
  logic busy_q, busy_d;
  logic ilv_q, ilv_d;
  logic full_q, full_d;
  logic [COL_W-1:0] base_q, base_d;
  logic [COL_W-1:0] cnt_q, cnt_d;
  logic [COL_W-1:0] mask_q, mask_d;
  logic [COL_W-1:0] seq_col;

  function automatic logic [COL_W-1:0] len_mask(input logic [MR_BLEN_W-1:0] code);
    logic [COL_W-1:0] m;
    m = '0;
    unique case (code)
      BLEN_2: m = COL_W'(1);
      BLEN_4: m = COL_W'(3);
      BLEN_8: m = COL_W'(7);
      BLEN_FULL: m = '1;
      default: m = '0;
    endcase
    return m;
  endfunction : len_mask

  always_comb
  begin
    base_d = start_in ? start_col_in : base_q;
    cnt_d = start_in ? '0 : cnt_q;
    mask_d = start_in ? len_mask(len_code_in) : mask_q;
    full_d = start_in ? (len_code_in == BLEN_FULL) : full_q;
    ilv_d = start_in ? (interleave_in && len_code_in != BLEN_FULL) : ilv_q;
    seq_col = base_d + cnt_d;
    col_out = ilv_d ? (base_d ^ cnt_d) : ((base_d & ~mask_d) | (seq_col & mask_d));
    valid_out = (start_in || busy_q) && !stop_in;
    last_out = valid_out && !full_d && (cnt_d == mask_d);
    busy_d = valid_out && !last_out;
    cnt_d = cnt_d + COL_W'(1);
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_q <= 1'b0;
      ilv_q <= 1'b0;
      full_q <= 1'b0;
      base_q <= '0;
      cnt_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      busy_q <= busy_d;
      ilv_q <= ilv_d;
      full_q <= full_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
      mask_q <= mask_d;
    end
  end

  assign busy_out = busy_q;

  // ==========================================================================
  // Checks
  AST_BURST_FOUR_ENDS: assert property (@(posedge clk_in) disable iff (rst_in)
    (start_in && len_code_in == BLEN_4) ##1 (!start_in && !stop_in) [*3] |-> last_out)
    else $error("burst of four did not end on its fourth column");

  AST_SECOND_COLUMN: assert property (@(posedge clk_in) disable iff (rst_in)
    (start_in && len_code_in == BLEN_2) ##1 (!start_in && !stop_in)
    |-> (col_out == ($past(start_col_in) ^ COL_W'(1))))
    else $error("second column of a burst of two is wrong");

  AST_FULL_PAGE_RUNS: assert property (@(posedge clk_in) disable iff (rst_in)
    (start_in && len_code_in == BLEN_FULL) ##1 (!start_in && !stop_in) [*4] |-> busy_out)
    else $error("full page burst stopped by itself");

endmodule : sdb_burst
`default_nettype wire

// ==== rtl/sdb_sdram_core.sv ====
// SDRAM command side: capture, decode, banks, bursts, refresh and a data array.
// Assumes a controller on the same clock drives the pins; the array keeps only a
// few low row and column bits, so distant addresses alias.
//
// Operation
// - All pins are captured on the rising clock edge only.
// - Four-bit part: four banks of 8192 rows by 2048 four-bit columns.
// - Byte part: four banks of 8192 rows by 1024 byte columns.
// - Sixteen-bit part: four banks of 8192 rows by 512 sixteen-bit columns.
// - Activate takes bank inputs as bank and thirteen address bits as row.
// - Read or write takes the sampled address as the burst's first column.
// - The device steps the columns itself in the programmed order; full page always steps sequentially.
// - Burst lengths one, two, four, eight or full page; terminate cuts short.
// - Auto-precharge closes the row itself once the burst ends, except after a burst terminate.
// - A new column access may start on every clock cycle.
// - One bank may precharge while another bank is accessed.
// - Auto refresh and power-down modes are available to the controller.
// - Address bit ten on read or write selects auto-precharge, not column.
// - Chip select high masks commands; running bursts still complete.
// - Column bits: A9..A0 plus A11, A9..A0, or A8..A0 by width.
`timescale 1ns/10ps
`default_nettype none
module sdb_sdram_core
  import sdb_pkg::*;
#(
  parameter int DQ_W = DQ_W_X16,
  parameter bit AUTOMOTIVE_GRADE = 1'b0,
  parameter int ROW_KEEP = 2,
  parameter int COL_KEEP = 4
)(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Command pins
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [BANK_W-1:0] ba_in,
  input wire logic [ADDR_W-1:0] addr_in,
  // Data pins
  input wire logic dqm_in,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe_out,
  // Status
  output logic [NUM_BANKS-1:0] bank_open_out
);

  localparam int COL_W = (DQ_W == DQ_W_X4) ? COL_W_X4 :
                         (DQ_W == DQ_W_X8) ? COL_W_X8 : COL_W_X16;
  localparam int MEM_AW = BANK_W + ROW_KEEP + COL_KEEP;
  localparam int MEM_DEPTH = 1 << MEM_AW;

  // ==========================================================================
  // Pin capture
  logic cke_q;
  logic cs_n_q;
  logic [2:0] cmd_q;
  logic [BANK_W-1:0] ba_q;
  logic [ADDR_W-1:0] addr_q;
  logic dqm_q;
  logic [DQ_W-1:0] dq_cap_q;

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cke_q <= 1'b0;
      cs_n_q <= 1'b1;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
      dqm_q <= 1'b1;
      dq_cap_q <= '0;
    end
    else
    begin
      cke_q <= cke_in;
      cs_n_q <= cs_n_in;
      cmd_q <= {ras_n_in, cas_n_in, we_n_in};
      ba_q <= ba_in;
      addr_q <= addr_in;
      dqm_q <= dqm_in;
      dq_cap_q <= dq_in;
    end
  end

  // ==========================================================================
  // Decode
  sdb_state_e st_q, st_d;
  sdb_cmd_e cmd;
  logic [ADDR_W-1:0] mode_q, mode_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [ROW_W-1:0] ref_row_q, ref_row_d;
  logic ap_q, ap_d;
  logic [BANK_W-1:0] bbank_q, bbank_d;
  logic bwr_q, bwr_d;
  logic sel;
  logic rw_start;
  logic is_wr;
  logic burst_stop;
  logic all_idle;
  logic ap_end;
  logic ap_cut;
  logic [COL_W-1:0] start_col;
  logic [MR_BLEN_W-1:0] len_code;
  logic [BANK_W-1:0] cur_bank;
  logic cur_wr;
  logic b_valid;
  logic b_busy;
  logic b_last;
  logic [COL_W-1:0] b_col;
  logic [NUM_BANKS-1:0] bank_open;
  logic [NUM_BANKS-1:0] bank_idle;
  logic [NUM_BANKS-1:0] bank_act;
  logic [NUM_BANKS-1:0] bank_pre;
  logic [ROW_W-1:0] bank_row [NUM_BANKS];

  assign cmd = sdb_cmd_e'(cmd_q);
  assign sel = !cs_n_q && cke_q && (st_q == ST_RUN);
  assign all_idle = &bank_idle;
  assign is_wr = (cmd == CMD_WR);
  // Access to a closed bank is dropped; the controller keeps the order
  assign rw_start = sel && (cmd == CMD_RD || is_wr) && bank_open[ba_q];
  assign len_code = (is_wr && mode_q[MR_WB_BIT]) ? BLEN_1 : mode_q[MR_BLEN_LSB +: MR_BLEN_W];
  assign burst_stop = !rw_start && sel && ((cmd == CMD_BST) ||
    (cmd == CMD_PRE && (addr_q[PRECHARGE_SELECT_BIT] || ba_q == bbank_q)));
  assign cur_bank = rw_start ? ba_q : bbank_q;
  assign cur_wr = rw_start ? is_wr : bwr_q;

  // Bit ten never reaches the column
  always_comb
  begin
    if (DQ_W == DQ_W_X4)
      start_col = COL_W'({addr_q[X4_COL_TOP_BIT], addr_q[9:0]});
    else
      start_col = addr_q[COL_W-1:0];
  end

  // Auto-precharge at burst end, or when a new access cuts the burst
  assign ap_end = b_valid && b_last && (rw_start ? addr_q[PRECHARGE_SELECT_BIT] : ap_q);
  assign ap_cut = rw_start && b_busy && ap_q;

  sdb_burst #(
    .COL_W(COL_W)
  ) u_burst (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(rw_start),
    .start_col_in(start_col),
    .len_code_in(len_code),
    .interleave_in(mode_q[MR_BT_BIT]),
    .stop_in(burst_stop),
    .valid_out(b_valid),
    .busy_out(b_busy),
    .last_out(b_last),
    .col_out(b_col)
  );

  // ==========================================================================
  // Banks
  for (genvar i = 0; i < NUM_BANKS; i++)
  begin : g_bank
    assign bank_act[i] = sel && (cmd == CMD_ACT) && (ba_q == BANK_W'(i));
    assign bank_pre[i] = (sel && cmd == CMD_PRE &&
                          (addr_q[PRECHARGE_SELECT_BIT] || ba_q == BANK_W'(i))) ||
                         (ap_end && cur_bank == BANK_W'(i)) ||
                         (ap_cut && bbank_q == BANK_W'(i));
    sdb_bank u_bank (
      .clk_in(ref_clk_in),
      .rst_in(rst_in),
      .act_in(bank_act[i]),
      .row_in(addr_q[ROW_W-1:0]),
      .pre_in(bank_pre[i]),
      .open_out(bank_open[i]),
      .idle_out(bank_idle[i]),
      .row_out(bank_row[i])
    );
  end

  assign bank_open_out = bank_open;

  // ==========================================================================
  // Mode, refresh and power state
  always_comb
  begin
    st_d = st_q;
    tmr_d = tmr_q;
    mode_d = mode_q;
    ref_row_d = ref_row_q;
    ap_d = ap_q;
    bbank_d = bbank_q;
    bwr_d = bwr_q;
    if (rw_start)
    begin
      ap_d = addr_q[PRECHARGE_SELECT_BIT];
      bbank_d = ba_q;
      bwr_d = is_wr;
    end
    unique case (st_q)
      ST_RUN:
      begin
        if (sel && cmd == CMD_LMR && all_idle && !b_busy)
          mode_d = addr_q;
        if (sel && cmd == CMD_REF && all_idle && !b_busy)
        begin
          st_d = ST_REFRESH;
          tmr_d = TMR_W'(TRFC_CYC - 1);
          ref_row_d = ref_row_q + ROW_W'(1);
        end
        else if (!cke_q && !b_busy)
        begin
          // The automotive grade falls back to power-down instead
          if (!cs_n_q && cmd == CMD_REF && all_idle && !AUTOMOTIVE_GRADE)
          begin
            st_d = ST_SELF;
            tmr_d = TMR_W'(TRFC_CYC - 1);
          end
          else
            st_d = ST_PDOWN;
        end
      end
      ST_REFRESH:
      begin
        if (tmr_q == '0)
          st_d = ST_RUN;
        else
          tmr_d = tmr_q - TMR_W'(1);
      end
      ST_PDOWN:
      begin
        if (cke_q)
          st_d = ST_RUN;
      end
      ST_SELF:
      begin
        if (cke_q)
          st_d = ST_RUN;
        else if (tmr_q == '0)
        begin
          tmr_d = TMR_W'(TRFC_CYC - 1);
          ref_row_d = ref_row_q + ROW_W'(1);
        end
        else
          tmr_d = tmr_q - TMR_W'(1);
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= ST_RUN;
      tmr_q <= '0;
      mode_q <= MODE_RESET;
      ref_row_q <= '0;
      ap_q <= 1'b0;
      bbank_q <= '0;
      bwr_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      mode_q <= mode_d;
      ref_row_q <= ref_row_d;
      ap_q <= ap_d;
      bbank_q <= bbank_d;
      bwr_q <= bwr_d;
    end
  end

  // ==========================================================================
  // Data array and read pipeline
  logic [DQ_W-1:0] mem_q [MEM_DEPTH];
  logic [MEM_AW-1:0] mem_idx;
  logic wr_fire;
  logic cl3;
  logic [1:0] pv_q, pv_d;
  logic [DQ_W-1:0] pd_q [2];
  logic [DQ_W-1:0] pd_d [2];
  logic [DQ_W-1:0] dq_q, dq_d;
  logic oe_q, oe_d;

  assign mem_idx = {cur_bank, bank_row[cur_bank][ROW_KEEP-1:0], b_col[COL_KEEP-1:0]};
  assign wr_fire = b_valid && cur_wr && !dqm_q;
  assign cl3 = (mode_q[MR_CL_LSB +: MR_CL_W] == CL_CODE_3);

  // Flops without reset: the array holds no control state
  always_ff @(posedge ref_clk_in)
  begin
    if (wr_fire)
      mem_q[mem_idx] <= dq_cap_q;
  end

  always_comb
  begin
    pv_d[0] = b_valid && !cur_wr && !dqm_q;
    pd_d[0] = mem_q[mem_idx];
    pv_d[1] = pv_q[0];
    pd_d[1] = pd_q[0];
    dq_d = cl3 ? pd_q[1] : pd_q[0];
    oe_d = cl3 ? pv_q[1] : pv_q[0];
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pv_q <= '0;
      pd_q[0] <= '0;
      pd_q[1] <= '0;
      dq_q <= '0;
      oe_q <= 1'b0;
    end
    else
    begin
      pv_q <= pv_d;
      pd_q[0] <= pd_d[0];
      pd_q[1] <= pd_d[1];
      dq_q <= dq_d;
      oe_q <= oe_d;
    end
  end

  assign dq_out = dq_q;
  assign dq_oe_out = oe_q;

  // ==========================================================================
  // Checks
  AST_READ_LATENCY_2: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (rw_start && !is_wr && !dqm_q && !cl3) ##1 !cl3 |-> ##1 dq_oe_out)
    else $error("read data late at latency two");

  AST_WRITE_STORES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_fire |=> (mem_q[$past(mem_idx)] == $past(dq_cap_q)))
    else $error("write data not stored");

  AST_CS_MASKS_MODE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cs_n_q |=> $stable(mode_q))
    else $error("mode changed while deselected");

  AST_CS_KEEPS_BURST: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (b_busy && cs_n_q) |-> b_valid)
    else $error("deselect stopped a running burst");

  AST_AUTO_PRE_CLOSES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ap_end && !rw_start) |=> !bank_open_out[$past(bbank_q)])
    else $error("auto-precharge left the row open");

  AST_REFRESH_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (st_q == ST_RUN && st_d == ST_REFRESH) |=> (st_q == ST_REFRESH) [*7] ##1 (st_q == ST_RUN))
    else $error("refresh busy time wrong");

  AST_NO_SELF_REFRESH: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    AUTOMOTIVE_GRADE |-> (st_q != ST_SELF))
    else $error("self refresh entered on automotive grade");

  AST_POWER_DOWN_IGNORES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (st_q == ST_PDOWN) |-> (bank_act == '0 && !rw_start))
    else $error("command taken in power-down");

endmodule : sdb_sdram_core
`default_nettype wire

// ==== verif/sdb_ctrl_model.sv ====
// Controller model: drives the command, address and data pins of the device.
// Assumes the bench calls its tasks in order, one command per clock cycle.
`timescale 1ns/10ps
`default_nettype none
module sdb_ctrl_model
  import sdb_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Command pins
  output logic cke_out,
  output logic cs_n_out,
  output logic ras_n_out,
  output logic cas_n_out,
  output logic we_n_out,
  output logic [BANK_W-1:0] ba_out,
  output logic [ADDR_W-1:0] addr_out,
  // Data pins
  output logic [DQ_W_X16-1:0] dq_out
);
  // ==========================================================================
  // Idle state; clock enable held high, so self refresh is never requested
  initial
  begin
    cke_out = 1'b1;
    cs_n_out = 1'b0;
    {ras_n_out, cas_n_out, we_n_out} = CMD_NOP;
    ba_out = 2'h0;
    addr_out = 13'h0000;
    dq_out = 16'h0000;
  end

  // ==========================================================================
  // One command per cycle, changed just after the falling edge
  task automatic issue(input logic cs_n, input sdb_cmd_e c, input logic [BANK_W-1:0] ba,
                       input logic [ADDR_W-1:0] a, input logic [DQ_W_X16-1:0] d);
    @(negedge clk_in);
    cs_n_out = cs_n;
    {ras_n_out, cas_n_out, we_n_out} = c;
    ba_out = ba;
    addr_out = a;
    dq_out = d;
  endtask : issue

  // Released data lines show the inverse, so stale values never match
  task automatic nop();
    issue(1'b0, CMD_NOP, 2'h0, 13'h0000, ~dq_out);
  endtask : nop
endmodule : sdb_ctrl_model
`default_nettype wire

// ==== verif/test_sdram_bank_burst_access.sv ====
// Self-checking bench of the SDRAM command side, sixteen-bit configuration.
// Assumes the controller model drives every pin except clock, reset and data mask.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_sdram_bank_burst_access
  import sdb_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic dqm_in = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n, oe;
  logic [BANK_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W_X16-1:0] dq_w, dq_r;
  logic [NUM_BANKS-1:0] bank_open;
  int error_cnt = 0;
  int checks = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  sdb_ctrl_model ctl (.clk_in(ref_clk_in), .cke_out(cke), .cs_n_out(cs_n),
    .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .ba_out(ba),
    .addr_out(addr), .dq_out(dq_w));

  sdb_sdram_core #(.DQ_W(DQ_W_X16)) uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
    .ba_in(ba), .addr_in(addr), .dqm_in(dqm_in), .dq_in(dq_w), .dq_out(dq_r),
    .dq_oe_out(oe), .bank_open_out(bank_open));

  // ==========================================================================
  // Shared helpers
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // Bounded wait for an exact open-bank pattern
  task automatic wait_open(input logic [NUM_BANKS-1:0] exp, input int lim);
    int i;
    for (i = 0; i < lim && bank_open !== exp; i++)
      @(negedge ref_clk_in);
    `CHK("bank_open", exp, bank_open)
    if (bank_open !== exp)
      tally_and_finish();
  endtask : wait_open

  task automatic wr2(input logic [1:0] b, input logic [12:0] a, input logic [15:0] d0,
                     input logic [15:0] d1);
    ctl.issue(1'b0, CMD_WR, b, a, d0);
    ctl.issue(1'b0, CMD_NOP, 2'h0, 13'h0000, d1);
    ctl.nop();
  endtask : wr2

  // Two-word read; the first word must come back within a short bound
  task automatic rd2(input logic [1:0] b, input logic [12:0] a, input logic [15:0] e0,
                     input logic [15:0] e1);
    int i;
    ctl.issue(1'b0, CMD_RD, b, a, 16'h0000);
    ctl.nop();
    for (i = 0; i < 6 && oe !== 1'b1; i++)
      @(negedge ref_clk_in);
    `CHK("oe_first", 1'b1, oe)
    if (oe !== 1'b1)
      tally_and_finish();
    `CHK("dq_first", e0, dq_r)
    @(negedge ref_clk_in);
    `CHK("oe_second", 1'b1, oe)
    `CHK("dq_second", e1, dq_r)
    @(negedge ref_clk_in);
    `CHK("oe_end", 1'b0, oe)
  endtask : rd2

  // ==========================================================================
  // Scenarios
  task automatic t_open_and_burst();
    ctl.issue(1'b0, CMD_LMR, 2'h0, 13'h0021, 16'h0000);
    ctl.nop();
    ctl.issue(1'b0, CMD_ACT, 2'h0, 13'h1005, 16'h0000);
    ctl.nop();
    wait_open(4'h1, 4);
    wr2(2'h0, 13'h0002, 16'hA1A1, 16'hB2B2);
    // Start on the odd column so the burst must wrap within its pair
    rd2(2'h0, 13'h0003, 16'hB2B2, 16'hA1A1);
  endtask : t_open_and_burst

  task automatic t_cs_mask();
    int i;
    ctl.issue(1'b1, CMD_ACT, 2'h2, 13'h0007, 16'h0000);
    for (i = 0; i < 4; i++)
      ctl.nop();
    `CHK("bank_open_masked", 4'h1, bank_open)
  endtask : t_cs_mask

  task automatic t_auto_precharge();
    rd2(2'h0, 13'h0402, 16'hA1A1, 16'hB2B2);
    wait_open(4'h0, 8);
  endtask : t_auto_precharge

  task automatic t_hidden_precharge();
    ctl.issue(1'b0, CMD_ACT, 2'h0, 13'h0005, 16'h0000);
    ctl.issue(1'b0, CMD_ACT, 2'h1, 13'h0009, 16'h0000);
    ctl.nop();
    wait_open(4'h3, 4);
    ctl.issue(1'b0, CMD_PRE, 2'h0, 13'h0000, 16'h0000);
    // Bank one is written while bank zero is still closing
    wr2(2'h1, 13'h0006, 16'h5C3E, 16'h0F0F);
    rd2(2'h1, 13'h0006, 16'h5C3E, 16'h0F0F);
    `CHK("bank_open_after_pre", 4'h2, bank_open)
  endtask : t_hidden_precharge

  // Refresh hides an activate; then an interleaved burst of four at latency three, cut short
  task automatic t_refresh_and_cut();
    ctl.issue(1'b0, CMD_PRE, 2'h0, 13'h0400, 16'h0000);
    ctl.nop();
    wait_open(4'h0, 4);
    ctl.nop();
    ctl.issue(1'b0, CMD_REF, 2'h0, 13'h0000, 16'h0000);
    ctl.issue(1'b0, CMD_ACT, 2'h2, 13'h0003, 16'h0000);
    repeat (8) ctl.nop();
    `CHK("bank_open_refresh", 4'h0, bank_open)
    ctl.issue(1'b0, CMD_LMR, 2'h0, 13'h003A, 16'h0000);
    ctl.nop();
    ctl.issue(1'b0, CMD_ACT, 2'h2, 13'h0003, 16'h0000);
    ctl.nop();
    wait_open(4'h4, 4);
    ctl.issue(1'b0, CMD_WR, 2'h2, 13'h0004, 16'h4444);
    ctl.issue(1'b0, CMD_NOP, 2'h0, 13'h0000, 16'h5555);
    ctl.issue(1'b0, CMD_NOP, 2'h0, 13'h0000, 16'h6666);
    ctl.issue(1'b0, CMD_NOP, 2'h0, 13'h0000, 16'h7777);
    ctl.nop();
    ctl.issue(1'b0, CMD_RD, 2'h2, 13'h0005, 16'h0000);
    ctl.nop();
    // Terminate after two columns; interleaved order from five is 5, 4, 7, 6
    ctl.issue(1'b0, CMD_BST, 2'h0, 13'h0000, 16'h0000);
    ctl.nop();
    `CHK("oe_cl3_early", 1'b0, oe)
    @(negedge ref_clk_in);
    `CHK("oe_cl3", 1'b1, oe)
    `CHK("dq_ilv_first", 16'h5555, dq_r)
    @(negedge ref_clk_in);
    `CHK("dq_ilv_second", 16'h4444, dq_r)
    @(negedge ref_clk_in);
    `CHK("oe_cut", 1'b0, oe)
  endtask : t_refresh_and_cut

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    `CHK("bank_open_reset", 4'h0, bank_open)
    `CHK("oe_reset", 1'b0, oe)
    t_open_and_burst();
    t_cs_mask();
    t_auto_precharge();
    t_hidden_precharge();
    t_refresh_and_cut();
    tally_and_finish();
  end
endmodule : test_sdram_bank_burst_access
`default_nettype wire
